// file: cpw_pkg.sv
package cpw_pkg;

    // ==========================================================
    // register indices (byte address = 4 * index)
    // ==========================================================
    localparam int IDX_W = 8;
    localparam logic [IDX_W-1:0] IDX_GEN_CONF   = 8'h00;
    localparam logic [IDX_W-1:0] IDX_REF_CONF   = 8'h01;
    localparam logic [IDX_W-1:0] IDX_EVENTS     = 8'h0E;
    localparam logic [IDX_W-1:0] IDX_EVT_MASK   = 8'h0F;
    localparam logic [IDX_W-1:0] IDX_RAMP_MODE  = 8'h20;
    localparam logic [IDX_W-1:0] IDX_ACTUAL     = 8'h21;
    localparam logic [IDX_W-1:0] IDX_SOFT_LOW   = 8'h33;
    localparam logic [IDX_W-1:0] IDX_SOFT_HIGH  = 8'h34;
    localparam logic [IDX_W-1:0] IDX_LATCH_REV  = 8'h36;
    localparam logic [IDX_W-1:0] IDX_TARGET     = 8'h37;
    localparam logic [IDX_W-1:0] IDX_REV_FRAC   = 8'h7C;

    // ==========================================================
    // field layout
    // ==========================================================
    localparam int GEN_REVS_SEL    = 0;
    localparam int REF_WRAP_EN     = 0;
    localparam int REF_LOW_EN      = 1;
    localparam int REF_HIGH_EN     = 2;
    localparam int REF_W           = 3;
    localparam int RAMP_POSITIONING = 2;
    localparam int RAMP_W          = 3;
    localparam int EVT_ZONE        = 0;
    localparam int EVT_REV         = 1;
    localparam int EVT_STRETCH     = 2;
    localparam int EVT_W           = 3;
    localparam int FRAC_W          = 31;
    localparam int ADDR_LSB        = 2;
    localparam int IDX_TOP         = ADDR_LSB + IDX_W;

    // ==========================================================
    // reset values and constants
    // ==========================================================
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [31:0] WORD_ONE  = 32'h0000_0001;

endpackage : cpw_pkg

// file: cpw_wrap.sv
// How it works
// (R1) with wrap enabled, actual position stays in [-half, half-1]
// (R2) step up from half-1 gives -half; step down from -half gives half-1
// (R3) positioning with wrap picks the shorter direction, possibly across the wrap
// (R4) revolution fraction extension at 0x7C is 1.31 fixed point
// (R5) each completed revolution adds the extension into a fraction accumulator
// (R6) accumulator overflow holds the position at the wrap point one extra step
// (R7) mean steps per revolution equal 2*half plus extension/2^31
// (R8) 0x80000000 stretches every revolution, 0x40000000 every second one
// (R9) revolution counter counts up on upward wrap, down on downward wrap
// (R10) reading 0x36 gives latched position, or revolution counter when selected
// (R11) revolution counter is cleared while wrap enable is 0
// (R12) software writes low and high soft limits then enables both
// (R13) positioning path avoids the blocking zone even if longer
// (R14) soft-limit deceleration requested on reaching the zone in velocity or zone-target
// (R15) low below high: zone is at or below low, or at or above high
// (R16) low above high: zone is at or below low and at or above high
// (R17) software writes non-zero half-range at 0x36 then sets wrap enable
// (R18) software leaves zone via positioning, event read-clear, outside target
// (R19) equal distances with no zone choose the positive direction
//
// The APB register port is this design's own decision.
module cpw_wrap #(
    parameter int ADDR_W = 12
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              stepReq,
    input  wire logic              stepDirPos,
    input  wire logic              latchReq,
    output logic      [31:0]       actualPos,
    output logic                   moveDirPos,
    output logic                   softStopReq,
    output logic                   irq
);

    // ==========================================================
    // elaboration check
    // ==========================================================
    if (ADDR_W < cpw_pkg::IDX_TOP)
    begin : g_bad_addr
        $error("cpw_wrap: ADDR_W too small for register map");
    end

    // ==========================================================
    // helpers
    // ==========================================================
    // forward modular distance from a to b on a ring of span steps
    function automatic logic [32:0] cpw_mod_dist(
        input logic [31:0] a,
        input logic [31:0] b,
        input logic [32:0] span
    );
        logic [33:0] d;
        d = {{2{b[31]}}, b} - {{2{a[31]}}, a};
        if (d[33])
        begin
            d = d + {1'b0, span};
        end
        return d[32:0];
    endfunction : cpw_mod_dist

    function automatic logic cpw_in_zone(
        input logic signed [31:0] pos,
        input logic signed [31:0] low,
        input logic signed [31:0] high
    );
        if (low < high)
        begin
            return (pos <= low) || (pos >= high); // [R15]
        end
        return (pos <= low) && (pos >= high); // [R16]
    endfunction : cpw_in_zone

    // ==========================================================
    // state
    // ==========================================================
    logic                        genConf_r;
    logic [cpw_pkg::REF_W-1:0]   refConf_r;
    logic [cpw_pkg::RAMP_W-1:0]  ramp_mode_select_r;
    logic [cpw_pkg::EVT_W-1:0]   events_r;
    logic [cpw_pkg::EVT_W-1:0]   evtMask_r;
    logic [31:0]                 target_r;
    logic [31:0]                 softLow_r;
    logic [31:0]                 softHigh_r;
    logic [31:0]                 halfRange_r;
    logic [31:0]                 revFrac_r;
    logic [31:0]                 latchPos_r;
    logic [31:0]                 revCnt_r;
    logic [cpw_pkg::FRAC_W-1:0]  fracAcc_r;
    logic [1:0]                  holdCnt_r;
    logic [31:0]                 actualPos_r;
    logic                        moveDirPos_r;
    logic                        softStopReq_r;
    logic                        irq_r;
    logic [31:0]                 prdata_r;
    logic                        pready_r;
    logic                        pslverr_r;

    // ==========================================================
    // apb decode
    // ==========================================================
    wire [cpw_pkg::IDX_W-1:0] idx = paddr[cpw_pkg::IDX_TOP-1:cpw_pkg::ADDR_LSB];
    wire addrOk   = (paddr[cpw_pkg::ADDR_LSB-1:0] == '0)
                    && ((paddr >> cpw_pkg::IDX_TOP) == '0);
    wire accWait  = psel && penable && !pready_r;
    wire accDone  = psel && penable && pready_r;
    wire wrDone   = accDone && pwrite && addrOk;
    wire rdDone   = accDone && !pwrite && addrOk;
    wire wrGen    = wrDone && (idx == cpw_pkg::IDX_GEN_CONF);
    wire wrRef    = wrDone && (idx == cpw_pkg::IDX_REF_CONF);
    wire wrEvt    = wrDone && (idx == cpw_pkg::IDX_EVENTS);
    wire wrMask   = wrDone && (idx == cpw_pkg::IDX_EVT_MASK);
    wire wrRamp   = wrDone && (idx == cpw_pkg::IDX_RAMP_MODE);
    wire wrActual = wrDone && (idx == cpw_pkg::IDX_ACTUAL);
    wire wrTarget = wrDone && (idx == cpw_pkg::IDX_TARGET);
    wire wrLow    = wrDone && (idx == cpw_pkg::IDX_SOFT_LOW);
    wire wrHigh   = wrDone && (idx == cpw_pkg::IDX_SOFT_HIGH);
    wire wrHalf   = wrDone && (idx == cpw_pkg::IDX_LATCH_REV);
    wire wrFrac   = wrDone && (idx == cpw_pkg::IDX_REV_FRAC);
    // event read clears as well as write-one clear
    wire rdEvt    = rdDone && (idx == cpw_pkg::IDX_EVENTS); // [R18]

    logic [31:0] rdMux;
    logic        rdHit;
    wire  [31:0] latchOrRev = genConf_r ? revCnt_r : latchPos_r; // [R10]

    always_comb
    begin
        rdHit = 1'b1;
        unique case (idx)
            cpw_pkg::IDX_GEN_CONF:  rdMux = 32'(genConf_r);
            cpw_pkg::IDX_REF_CONF:  rdMux = 32'(refConf_r);
            cpw_pkg::IDX_EVENTS:    rdMux = 32'(events_r);
            cpw_pkg::IDX_EVT_MASK:  rdMux = 32'(evtMask_r);
            cpw_pkg::IDX_RAMP_MODE: rdMux = 32'(ramp_mode_select_r);
            cpw_pkg::IDX_ACTUAL:    rdMux = actualPos_r;
            cpw_pkg::IDX_TARGET:    rdMux = target_r;
            cpw_pkg::IDX_SOFT_LOW:  rdMux = softLow_r;
            cpw_pkg::IDX_SOFT_HIGH: rdMux = softHigh_r;
            cpw_pkg::IDX_LATCH_REV: rdMux = latchOrRev;
            cpw_pkg::IDX_REV_FRAC:  rdMux = revFrac_r;
            default:
            begin
                rdMux = cpw_pkg::WORD_ZERO;
                rdHit = 1'b0;
            end
        endcase
        if (!addrOk)
        begin
            rdMux = cpw_pkg::WORD_ZERO;
            rdHit = 1'b0;
        end
    end

    // ==========================================================
    // wrap arithmetic
    // ==========================================================
    // zero half-range keeps wrap off even with the enable set
    wire        wrapEn   = refConf_r[cpw_pkg::REF_WRAP_EN];
    wire        wrapOn   = wrapEn && (halfRange_r != cpw_pkg::WORD_ZERO); // [R17]
    wire [32:0] span     = {halfRange_r, 1'b0};
    wire [31:0] negHalf  = cpw_pkg::WORD_ZERO - halfRange_r;
    wire [31:0] wrapTop  = halfRange_r - cpw_pkg::WORD_ONE;
    wire        crossUp  = stepReq && stepDirPos && wrapOn && (actualPos_r == wrapTop);
    wire        crossDn  = stepReq && !stepDirPos && wrapOn && (actualPos_r == negHalf);
    wire        crossing = crossUp || crossDn;
    wire        holdBusy = holdCnt_r != 2'b00;
    wire        stretch  = crossing && holdBusy;
    wire        moved    = crossing && !holdBusy;
    // 1.31 extension on a 0.31 accumulator: integer part is the hold count
    wire [32:0] fracSum  = {2'b00, fracAcc_r} + {1'b0, revFrac_r}; // [R4] [R7] [R8]

    logic [31:0] actualNxt;
    always_comb
    begin
        if (wrActual)
        begin
            actualNxt = pwdata;
        end
        else if (stretch)
        begin
            actualNxt = actualPos_r; // [R6]
        end
        else if (moved)
        begin
            actualNxt = crossUp ? negHalf : wrapTop; // [R1] [R2]
        end
        else if (stepReq)
        begin
            actualNxt = stepDirPos ? actualPos_r + cpw_pkg::WORD_ONE
                                   : actualPos_r - cpw_pkg::WORD_ONE;
        end
        else
        begin
            actualNxt = actualPos_r;
        end
    end

    wire [31:0] revNxt = !wrapEn ? cpw_pkg::WORD_ZERO                 // [R11]
                       : (moved && crossUp) ? revCnt_r + cpw_pkg::WORD_ONE  // [R9]
                       : (moved && crossDn) ? revCnt_r - cpw_pkg::WORD_ONE
                       : revCnt_r;

    // ==========================================================
    // direction and blocking zone
    // ==========================================================
    wire        positioning = ramp_mode_select_r[cpw_pkg::RAMP_POSITIONING];
    wire        zoneOn   = wrapOn && refConf_r[cpw_pkg::REF_LOW_EN]
                           && refConf_r[cpw_pkg::REF_HIGH_EN]; // [R12]
    wire [32:0] fwdDist  = cpw_mod_dist(actualPos_r, target_r, span);
    wire [32:0] bwdDist  = span - fwdDist;
    wire [32:0] toHigh   = cpw_mod_dist(actualPos_r, softHigh_r, span);
    wire [32:0] toLow    = cpw_mod_dist(softLow_r, actualPos_r, span);
    wire        upBlock  = zoneOn && (toHigh <= fwdDist);
    wire        dnBlock  = zoneOn && (toLow <= bwdDist);
    wire        wrapDir  = (upBlock != dnBlock) ? !upBlock       // [R13]
                           : (fwdDist <= bwdDist);               // [R3] [R19]
    wire        plainDir = $signed(target_r) >= $signed(actualPos_r);
    wire        dirNxt   = !positioning ? moveDirPos_r
                           : wrapOn ? wrapDir : plainDir;
    wire        actInZone = cpw_in_zone(actualPos_r, softLow_r, softHigh_r);
    wire        tgtInZone = cpw_in_zone(target_r, softLow_r, softHigh_r);
    wire        stopNxt  = zoneOn && actInZone && (!positioning || tgtInZone); // [R14]

    // ==========================================================
    // events and interrupt
    // ==========================================================
    logic [cpw_pkg::EVT_W-1:0] evtSet;
    always_comb
    begin
        evtSet = '0;
        evtSet[cpw_pkg::EVT_ZONE]    = stopNxt && !softStopReq_r;
        evtSet[cpw_pkg::EVT_REV]     = moved;
        evtSet[cpw_pkg::EVT_STRETCH] = stretch;
    end
    wire [cpw_pkg::EVT_W-1:0] evtClr = rdEvt ? '1
                                     : wrEvt ? pwdata[cpw_pkg::EVT_W-1:0] : '0;
    // set wins over clear so an event in the clearing cycle is kept
    wire [cpw_pkg::EVT_W-1:0] eventsNxt = (events_r & ~evtClr) | evtSet;

    // ==========================================================
    // registers
    // ==========================================================
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            genConf_r   <= 1'b0;
            refConf_r   <= '0;
            ramp_mode_select_r  <= '0;
            evtMask_r   <= '0;
            target_r    <= cpw_pkg::WORD_ZERO;
            softLow_r   <= cpw_pkg::WORD_ZERO;
            softHigh_r  <= cpw_pkg::WORD_ZERO;
            halfRange_r <= cpw_pkg::WORD_ZERO;
            revFrac_r   <= cpw_pkg::WORD_ZERO;
        end
        else
        begin
            if (wrGen)    genConf_r   <= pwdata[cpw_pkg::GEN_REVS_SEL];
            if (wrRef)    refConf_r   <= pwdata[cpw_pkg::REF_W-1:0];
            if (wrRamp)   ramp_mode_select_r  <= pwdata[cpw_pkg::RAMP_W-1:0];
            if (wrMask)   evtMask_r   <= pwdata[cpw_pkg::EVT_W-1:0];
            if (wrTarget) target_r    <= pwdata;
            if (wrLow)    softLow_r   <= pwdata;
            if (wrHigh)   softHigh_r  <= pwdata;
            if (wrHalf)   halfRange_r <= pwdata;
            if (wrFrac)   revFrac_r   <= pwdata;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            actualPos_r <= cpw_pkg::WORD_ZERO;
            revCnt_r    <= cpw_pkg::WORD_ZERO;
            fracAcc_r   <= '0;
            holdCnt_r   <= 2'b00;
            latchPos_r  <= cpw_pkg::WORD_ZERO;
        end
        else
        begin
            actualPos_r <= actualNxt;
            revCnt_r    <= revNxt;
            if (moved)
            begin
                fracAcc_r <= fracSum[cpw_pkg::FRAC_W-1:0]; // [R5]
                holdCnt_r <= fracSum[32:31]; // [R6]
            end
            else if (stretch)
            begin
                holdCnt_r <= holdCnt_r - 2'b01;
            end
            if (latchReq) latchPos_r <= actualPos_r;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            events_r      <= '0;
            moveDirPos_r  <= 1'b1;
            softStopReq_r <= 1'b0;
            irq_r         <= 1'b0;
            prdata_r      <= cpw_pkg::WORD_ZERO;
            pready_r      <= 1'b0;
            pslverr_r     <= 1'b0;
        end
        else
        begin
            events_r      <= eventsNxt;
            moveDirPos_r  <= dirNxt;
            softStopReq_r <= stopNxt;
            irq_r         <= |(eventsNxt & evtMask_r);
            pready_r      <= accWait;
            pslverr_r     <= accWait && !rdHit;
            prdata_r      <= (accWait && !pwrite) ? rdMux : cpw_pkg::WORD_ZERO;
        end
    end

    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign actualPos   = actualPos_r;
    assign moveDirPos  = moveDirPos_r;
    assign softStopReq = softStopReq_r;
    assign irq         = irq_r;

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    wire inRange = ($signed(actualPos_r) >= $signed(negHalf))
                   && ($signed(actualPos_r) <= $signed(wrapTop));

    a_range_kept: assert property ( // [R1]
        wrapOn && inRange && !wrActual && !wrHalf ##1 wrapOn |-> inRange)
        else $error("actual position left the wrap range");
    a_wrap_up: assert property ( // [R2]
        crossUp && !holdBusy && !wrActual |=> actualPos_r == $past(negHalf))
        else $error("upward wrap did not load minus half-range");
    a_wrap_down: assert property ( // [R2]
        crossDn && !holdBusy && !wrActual |=> actualPos_r == $past(wrapTop))
        else $error("downward wrap did not load half-range minus one");
    a_short_dir: assert property ( // [R3]
        positioning && wrapOn && !zoneOn && (fwdDist < bwdDist) |=> moveDirPos_r)
        else $error("shorter positive path not chosen");
    a_tie_positive: assert property ( // [R19]
        positioning && wrapOn && !zoneOn && (fwdDist == bwdDist) |=> moveDirPos_r)
        else $error("tie did not choose positive direction");
    a_zone_avoid: assert property ( // [R13]
        positioning && upBlock && !dnBlock |=> !moveDirPos_r)
        else $error("path through blocking zone chosen");
    a_frac_add: assert property ( // [R5]
        moved |=> fracAcc_r == $past(fracSum[30:0]))
        else $error("fraction not accumulated on revolution");
    a_hold_step: assert property ( // [R6]
        stretch && !wrActual |=> $stable(actualPos_r)
        && (holdCnt_r == $past(holdCnt_r) - 2'b01))
        else $error("stretched step did not hold position");
    a_rev_count: assert property ( // [R9]
        moved && crossUp && wrapEn |=> revCnt_r == $past(revCnt_r) + 32'h0000_0001)
        else $error("revolution counter did not count up");
    a_rev_clear: assert property ( // [R11]
        !wrapEn |=> revCnt_r == cpw_pkg::WORD_ZERO)
        else $error("revolution counter not cleared");
    a_readback: assert property ( // [R10]
        accWait && !pwrite && addrOk && (idx == cpw_pkg::IDX_LATCH_REV)
        |=> prdata_r == $past(latchOrRev) && pready_r)
        else $error("wrong readback at latch address");
    a_zone_stop: assert property ( // [R14]
        stopNxt |=> softStopReq_r)
        else $error("deceleration not requested in zone");

    c_wrap_up:  cover property (moved && crossUp);
    c_stretch:  cover property (stretch ##[1:20] moved);
    c_zone_dir: cover property (positioning && upBlock && !dnBlock);
    c_irq:      cover property (irq_r ##[1:10] rdEvt);

endmodule : cpw_wrap

// file: tb_circular_position_wrap_unit.sv
module tb_circular_position_wrap_unit;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // stimulus signals
    // ==========================================================
    logic        clk_sys = 1'b0;
    logic        rst_n   = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic        stepReq = 1'b0;
    logic        stepDirPos = 1'b0;
    logic        latchReq = 1'b0;
    logic [31:0] prdata, actualPos;
    logic        pready, pslverr, moveDirPos, softStopReq, irq;
    logic [32:0] expQ[$];
    logic [15:0] lfsrState = 16'hD20D;
    int          bad_count = 0;
    int          compares  = 0;

    always #20 clk_sys = ~clk_sys;

    cpw_wrap #(.ADDR_W(12)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stepReq(stepReq), .stepDirPos(stepDirPos), .latchReq(latchReq),
        .actualPos(actualPos), .moveDirPos(moveDirPos), .softStopReq(softStopReq), .irq(irq)
    );

    // ==========================================================
    // compare and closing tasks
    // ==========================================================
    task automatic end_sim();
        $display("checks %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_sim

    task automatic cmp_pin(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %0t pin got %h want %h", $time, got, exp);
        end
    endtask : cmp_pin

    task automatic cmp_rd(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %0t read got %h want %h", $time, got, exp);
        end
    endtask : cmp_rd

    // read answers are matched against the oldest note
    always @(posedge clk_sys)
        if (psel && penable && pready === 1'b1 && (!pwrite || pslverr))
            cmp_rd({pslverr, prdata}, expQ.pop_front());

    // ==========================================================
    // drivers
    // ==========================================================
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                       input logic err = 1'b0);
        int n;
        n = 0;
        if (!wr || err)
            expQ.push_back({err, err ? 32'h0000_0000 : d});
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= wr ? d : 32'h0000_0000;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            bad_count++;
            $display("CHECK FAILED %0t no bus answer", $time);
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask : apb

    task automatic step(input logic dir);
        stepDirPos <= dir;
        stepReq    <= 1'b1;
        @(posedge clk_sys);
        stepReq    <= 1'b0;
        @(posedge clk_sys);
    endtask : step

    task automatic do_reset(input int n);
        rst_n <= 1'b0;
        repeat (n) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
    endtask : do_reset

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
    endfunction : lfsr_next

    // two revolution lengths for one fraction value, from a fresh reset
    task automatic rev_len(input logic [31:0] frac, input int e1, input int e2);
        int n;
        do_reset(2);
        apb(1, cpw_pkg::IDX_LATCH_REV, 32'h0000_0004);
        apb(1, cpw_pkg::IDX_REF_CONF, 32'h0000_0001);
        apb(1, cpw_pkg::IDX_REV_FRAC, frac);
        apb(0, cpw_pkg::IDX_REV_FRAC, frac);
        apb(1, cpw_pkg::IDX_ACTUAL, 32'h0000_0003);
        step(1);
        for (int r = 0; r < 2; r++)
        begin
            n = 0;
            do
            begin
                step(1);
                n++;
            end
            while (actualPos !== 32'hFFFF_FFFC && n < 20);
            cmp_pin(n, r == 0 ? e1 : e2);
        end
        apb(1, cpw_pkg::IDX_GEN_CONF, 32'h0000_0001);
        apb(0, cpw_pkg::IDX_LATCH_REV, 32'h0000_0003);
    endtask : rev_len

    task automatic dir_chk(input int pos, input int tgt, input logic e);
        apb(1, cpw_pkg::IDX_ACTUAL, pos);
        apb(1, cpw_pkg::IDX_TARGET, tgt);
        repeat (3) @(posedge clk_sys);
        cmp_pin(moveDirPos, e);
    endtask : dir_chk

    task automatic zone_chk(input int pos, input logic e);
        apb(1, cpw_pkg::IDX_ACTUAL, pos);
        repeat (3) @(posedge clk_sys);
        cmp_pin(softStopReq, e);
    endtask : zone_chk

    // ==========================================================
    // main sequence
    // ==========================================================
    initial
    begin
        int p;
        do_reset(16);
        apb(0, 8'h05, 32'h0000_0000, 1'b1);
        apb(0, cpw_pkg::IDX_ACTUAL, 32'h0000_0000);
        apb(1, cpw_pkg::IDX_LATCH_REV, 32'h0000_0004);
        apb(1, cpw_pkg::IDX_REF_CONF, 32'h0000_0001);
        apb(1, cpw_pkg::IDX_EVT_MASK, 32'h0000_0002);
        apb(1, cpw_pkg::IDX_ACTUAL, 32'h0000_0003);
        step(1);
        cmp_pin(actualPos, 32'hFFFF_FFFC);
        cmp_pin(irq, 32'h0000_0001);
        step(0);
        cmp_pin(actualPos, 32'h0000_0003);
        apb(1, cpw_pkg::IDX_GEN_CONF, 32'h0000_0001);
        apb(0, cpw_pkg::IDX_LATCH_REV, 32'h0000_0000);
        step(1);
        apb(0, cpw_pkg::IDX_LATCH_REV, 32'h0000_0001);
        apb(0, cpw_pkg::IDX_EVENTS, 32'h0000_0002);
        cmp_pin(irq, 32'h0000_0000);
        step(0);
        cmp_pin(irq, 32'h0000_0001);
        apb(1, cpw_pkg::IDX_EVENTS, 32'h0000_0002);
        cmp_pin(irq, 32'h0000_0000);
        apb(1, cpw_pkg::IDX_REF_CONF, 32'h0000_0000);
        apb(0, cpw_pkg::IDX_LATCH_REV, 32'h0000_0000);
        apb(1, cpw_pkg::IDX_GEN_CONF, 32'h0000_0000);
        for (int i = 0; i < 3; i++)
        begin
            lfsrState = lfsr_next(lfsrState);
            p = int'(lfsrState % 16'd600) - 300;
            apb(1, cpw_pkg::IDX_ACTUAL, p);
            latchReq <= 1'b1;
            @(posedge clk_sys);
            latchReq <= 1'b0;
            apb(0, cpw_pkg::IDX_LATCH_REV, p);
        end
        do_reset(2);
        apb(1, cpw_pkg::IDX_LATCH_REV, 32'h0000_012C);
        apb(1, cpw_pkg::IDX_REF_CONF, 32'h0000_0001);
        apb(1, cpw_pkg::IDX_RAMP_MODE, 32'h0000_0004);
        dir_chk(200, -200, 1'b1);
        dir_chk(0, -300, 1'b1);
        dir_chk(0, -10, 1'b0);
        apb(1, cpw_pkg::IDX_SOFT_LOW, 32'h0000_00FA);
        apb(1, cpw_pkg::IDX_SOFT_HIGH, 32'h0000_0096);
        apb(1, cpw_pkg::IDX_REF_CONF, 32'h0000_0007);
        dir_chk(100, 270, 1'b0);
        apb(1, cpw_pkg::IDX_EVT_MASK, 32'h0000_0001);
        apb(1, cpw_pkg::IDX_RAMP_MODE, 32'h0000_0000);
        zone_chk(200, 1'b1);
        cmp_pin(irq, 32'h0000_0001);
        zone_chk(100, 1'b0);
        apb(1, cpw_pkg::IDX_SOFT_LOW, -100);
        apb(1, cpw_pkg::IDX_SOFT_HIGH, 32'h0000_0064);
        zone_chk(150, 1'b1);
        zone_chk(0, 1'b0);
        rev_len(32'h0000_0000, 8, 8);
        rev_len(32'h4000_0000, 8, 9);
        rev_len(32'h8000_0000, 9, 9);
        repeat (4) @(posedge clk_sys);
        end_sim();
    end

    // generous limit: the whole sequence takes a few hundred cycles
    initial
    begin
        repeat (50000) @(posedge clk_sys);
        bad_count++;
        end_sim();
    end
endmodule : tb_circular_position_wrap_unit
